// ==== hw/uoy_ep_cfg.sv ====
// Purpose: Y-buffer count/flag and base address bytes of every OUT endpoint.
// Assumes: Buffer manager reports on the same clock; endpoint type and
//          bytes per sample come from the configuration bytes elsewhere.
// Notes:   Registers reached over AXI4-Lite; one shared interrupt, with a status and mask bit per endpoint.
`include "uoy_map.svh"
`timescale 1ns/1ps
`default_nettype none

module uoy_ep_cfg
    import uoy_pkg::*;
#(
    parameter int NUM_EP = 7
) (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic [`UOY_ADDR_W-1:0]        s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [`UOY_ADDR_W-1:0]        s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    input  wire uoy_pkt_t                      pkt,
    input  wire logic [NUM_EP-1:0]             ep_iso,
    input  wire logic [NUM_EP-1:0][1:0]        ep_bps,
    output logic [NUM_EP-1:0]                  ep_nack,
    output logic [NUM_EP-1:0][10:0]            y_start_addr,
    output logic                               irq
);

    // -----------------------------------------------------------------------
    // State
    // -----------------------------------------------------------------------
    typedef struct packed {
        uoy_ep_t [NUM_EP-1:0]      ep;
        logic    [NUM_EP-1:0]      stat;
        logic    [NUM_EP-1:0]      mask;
        logic                      aw_ok;
        logic [`UOY_ADDR_W-1:0]    awaddr;
        logic                      w_ok;
        logic [7:0]                wbyte;
        logic                      wlane;
        logic                      bvalid;
        logic [1:0]                bresp;
        logic                      rvalid;
        logic [31:0]               rdata;
        logic [1:0]                rresp;
    } uoy_state_t;

    uoy_state_t s;
    uoy_state_t next_s;

    logic [2:0]  wgrp;
    logic [2:0]  wword;
    logic [2:0]  rgrp;
    logic [2:0]  rword;
    logic [9:0]  samples;
    logic [2:0]  pep;

    // -----------------------------------------------------------------------
    // Handshake outputs
    // -----------------------------------------------------------------------
    // A new write is held off until its response has gone, so at most one
    // write is in flight.
    assign s_axi_awready = !s.aw_ok && !s.bvalid;
    assign s_axi_wready  = !s.w_ok && !s.bvalid;
    assign s_axi_arready = !s.rvalid;
    assign s_axi_bvalid  = s.bvalid;
    assign s_axi_bresp   = s.bresp;
    assign s_axi_rvalid  = s.rvalid;
    assign s_axi_rdata   = s.rdata;
    assign s_axi_rresp   = s.rresp;

    // -----------------------------------------------------------------------
    // Endpoint outputs
    // -----------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NUM_EP; i++) begin
            ep_nack[i]      = s.ep[i].flag && !ep_iso[i];
            y_start_addr[i] = {s.ep[i].base, 3'h0};
        end
    end

    assign irq = |(s.stat & s.mask);

    // -----------------------------------------------------------------------
    // Address decode
    // -----------------------------------------------------------------------
    assign wgrp  = s.awaddr[`UOY_GRP_LSB+2:`UOY_GRP_LSB];
    assign wword = s.awaddr[`UOY_GRP_LSB-1:`UOY_WORD_LSB];
    assign rgrp  = s_axi_araddr[`UOY_GRP_LSB+2:`UOY_GRP_LSB];
    assign rword = s_axi_araddr[`UOY_GRP_LSB-1:`UOY_WORD_LSB];
    assign pep   = pkt.ep;

    // -----------------------------------------------------------------------
    // Packet count
    // -----------------------------------------------------------------------
    // Bulk-type endpoints count bytes; isochronous ones count samples.
    always_comb begin
        samples = pkt.bytes;
        if (ep_iso[pep]) begin
            case (ep_bps[pep])
                `UOY_BPS_1: samples = pkt.bytes;
                `UOY_BPS_2: samples = pkt.bytes >> 1;
                `UOY_BPS_3: samples = pkt.bytes / 10'h003;
                `UOY_BPS_4: samples = pkt.bytes >> 2;
                default:    samples = pkt.bytes;
            endcase
        end
    end

    // -----------------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------------
    always_comb begin
        next_s = s;

        // Write address and data are latched separately, in either order.
        if (s_axi_awvalid && s_axi_awready) begin
            next_s.aw_ok  = 1'b1;
            next_s.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_s.w_ok  = 1'b1;
            next_s.wbyte = s_axi_wdata[7:0];
            next_s.wlane = s_axi_wstrb[0];
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end

        // Commit a write once both halves are held.
        if (s.aw_ok && s.w_ok) begin
            next_s.aw_ok  = 1'b0;
            next_s.w_ok   = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = `UOY_RESP_OKAY;
            if (s.awaddr == `UOY_OFS_STAT) begin
                if (s.wlane) begin
                    next_s.stat = s.stat & ~s.wbyte[NUM_EP-1:0];
                end
            end else if (s.awaddr == `UOY_OFS_MASK) begin
                if (s.wlane) begin
                    next_s.mask = s.wbyte[NUM_EP-1:0];
                end
            end else if (s.awaddr < `UOY_OFS_STAT && wgrp < NUM_EP) begin
                if (s.wlane && wword == `UOY_OFS_COUNT) begin
                    next_s.ep[wgrp].flag  = s.wbyte[`UOY_FLAG_BIT];
                    next_s.ep[wgrp].count = s.wbyte[`UOY_COUNT_MSB:0];
                end else if (s.wlane && wword == `UOY_OFS_BASE) begin
                    next_s.ep[wgrp].base = s.wbyte;
                end
            end else begin
                next_s.bresp = `UOY_RESP_SLVERR;
            end
        end

        // Buffer manager completion comes last so it wins over firmware.
        if (pkt.done && pep < NUM_EP) begin
            next_s.ep[pep].flag  = 1'b1;
            next_s.ep[pep].count = samples[6:0];
            next_s.stat[pep]     = 1'b1;
        end

        // Reads answer one cycle after the address is taken.
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_s.rvalid = 1'b1;
            next_s.rdata  = 32'h0000_0000;
            next_s.rresp  = `UOY_RESP_OKAY;
            if (s_axi_araddr == `UOY_OFS_STAT) begin
                next_s.rdata[NUM_EP-1:0] = s.stat;
            end else if (s_axi_araddr == `UOY_OFS_MASK) begin
                next_s.rdata[NUM_EP-1:0] = s.mask;
            end else if (s_axi_araddr < `UOY_OFS_STAT && rgrp < NUM_EP) begin
                if (rword == `UOY_OFS_COUNT) begin
                    next_s.rdata[7:0] = {s.ep[rgrp].flag, s.ep[rgrp].count};
                end else if (rword == `UOY_OFS_BASE) begin
                    next_s.rdata[7:0] = s.ep[rgrp].base;
                end
            end else begin
                next_s.rresp = `UOY_RESP_SLVERR;
            end
        end
    end

    // -----------------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            for (int i = 0; i < NUM_EP; i++) begin
                s.ep[i].flag  <= `UOY_FLAG_RST;
                s.ep[i].count <= `UOY_COUNT_RST;
                s.ep[i].base  <= `UOY_BASE_RST;
            end
        end else begin
            s <= next_s;
        end
    end

endmodule : uoy_ep_cfg

`default_nettype wire

// ==== hw/uoy_map.svh ====
// Purpose: Offsets, field positions, reset values and codes of the OUT endpoint Y-buffer block.
// Assumes: Byte addresses on a 32-bit AXI4-Lite slave, one register per aligned word.
// Notes:   Included by its bare name.
`ifndef UOY_MAP_SVH
`define UOY_MAP_SVH

// ---------------------------------------------------------------------------
// Register map
// ---------------------------------------------------------------------------
`define UOY_ADDR_W       12
`define UOY_GRP_STRIDE   12'h020
`define UOY_GRP_LSB      5
`define UOY_WORD_LSB     2
`define UOY_OFS_COUNT    3'h0
`define UOY_OFS_BASE     3'h1
`define UOY_OFS_STAT     12'h100
`define UOY_OFS_MASK     12'h104

// ---------------------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------------------
`define UOY_FLAG_BIT     7
`define UOY_COUNT_MSB    6
`define UOY_ADDR_LOW_W   3
`define UOY_COUNT_RST    7'h00
`define UOY_FLAG_RST     1'h0
`define UOY_BASE_RST     8'h00

// ---------------------------------------------------------------------------
// Bytes-per-sample codes and bus answers
// ---------------------------------------------------------------------------
`define UOY_BPS_1        2'h0
`define UOY_BPS_2        2'h1
`define UOY_BPS_3        2'h2
`define UOY_BPS_4        2'h3
`define UOY_RESP_OKAY    2'h0
`define UOY_RESP_SLVERR  2'h2

`endif

// ==== hw/uoy_pkg.sv ====
// Purpose: Types shared by the OUT endpoint Y-buffer block.
// Assumes: Constants live in uoy_map.svh.
// Notes:   One endpoint entry holds the count byte and the base byte.
package uoy_pkg;

    // -----------------------------------------------------------------------
    // Per-endpoint register pair
    // -----------------------------------------------------------------------
    typedef struct packed {
        logic       flag;
        logic [6:0] count;
        logic [7:0] base;
    } uoy_ep_t;

    // -----------------------------------------------------------------------
    // Completion report from the buffer manager
    // -----------------------------------------------------------------------
    typedef struct packed {
        logic       done;
        logic [2:0] ep;
        logic [9:0] bytes;
    } uoy_pkt_t;

endpackage : uoy_pkg

// ==== testbench/testbench.sv ====
// Purpose: Self-checking bench for uoy_ep_cfg.
// Assumes: Bench holds bready and rready high throughout.
// Notes:   Random values come from an LFSR with a fixed start.
`include "uoy_map.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench
    import uoy_pkg::*;
;
    localparam int NUM_EP = 7;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, irq, go, iso;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] go_ep;
    logic [9:0] go_bytes;
    logic [6:0] c;
    logic [NUM_EP-1:0] ep_iso, ep_nack;
    logic [NUM_EP-1:0][1:0] ep_bps;
    logic [NUM_EP-1:0][10:0] y_start_addr;
    uoy_pkt_t pkt;
    int fail_count = 0;
    int n_compared = 0;
    uoy_ep_cfg #(.NUM_EP(NUM_EP)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pkt, .ep_iso, .ep_bps,
        .ep_nack, .y_start_addr, .irq);
    uoy_host_model #(.NUM_EP(NUM_EP)) i_host (.aclk, .aresetn, .go, .go_ep, .go_bytes,
        .ep_nack, .pkt);
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    // Iso counts are whole samples; a partial sample is dropped.
    function automatic logic [6:0] exp_cnt(input logic [9:0] n, input logic i, input logic [1:0] b);
        logic [9:0] q;
        q = i ? n / ({8'h00, b} + 10'h001) : n;
        return q[6:0];
    endfunction : exp_cnt
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Local pending flags: the valid signals are assigned by NBA, so reading them
    // back in the same time step would still show the old value.
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_pend;
        logic w_pend;
        aw_pend = 1'b1;
        w_pend = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (aw_pend || w_pend) begin
            @(posedge aclk);
            if (aw_pend && s_axi_awready) begin
                aw_pend = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_pend && s_axi_wready) begin
                w_pend = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        chk(s_axi_bresp, er);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        chk(s_axi_rdata, ed);
        chk(s_axi_rresp, er);
    endtask : rd
    task automatic send(input int e, input logic [9:0] n);
        go <= 1'b1;
        go_ep <= 3'(e);
        go_bytes <= n;
        @(posedge aclk);
        go <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask : send
    task automatic complete_run();
        if (fail_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        complete_run();
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, go, go_ep, go_bytes} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ep_iso, ep_bps} = '0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb, seed} = {2'h3, 4'hF, 32'hE03F};
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(12'h004, 32'h0, `UOY_RESP_OKAY);
        rd(`UOY_OFS_STAT, 32'h0, `UOY_RESP_OKAY);
        for (int e = 0; e < NUM_EP; e++) begin
            seed = lfsr_next(seed);
            ep_iso[e] <= seed[0];
            ep_bps[e] <= seed[2:1];
            wr(12'(e * 32 + 4), {24'h0, seed[31:24]}, `UOY_RESP_OKAY);
            chk(y_start_addr[e], {21'h0, seed[31:24], 3'h0});
            send(e, seed[17:8]);
            iso = ep_iso[e];
            c = exp_cnt(seed[17:8], iso, ep_bps[e]);
            rd(12'(e * 32), {24'h0, 1'b1, c}, `UOY_RESP_OKAY);
            chk(ep_nack[e], !iso);
            seed = lfsr_next(seed);
            send(e, seed[9:0]);
            c = iso ? exp_cnt(seed[9:0], iso, ep_bps[e]) : c;
            rd(12'(e * 32), {24'h0, 1'b1, c}, `UOY_RESP_OKAY);
            wr(12'(e * 32), 32'h0, `UOY_RESP_OKAY);
            chk(ep_nack[e], 1'b0);
        end
        rd(`UOY_OFS_STAT, 32'h7F, `UOY_RESP_OKAY);
        wr(`UOY_OFS_MASK, 32'h1, `UOY_RESP_OKAY);
        chk(irq, 1'b1);
        wr(`UOY_OFS_STAT, 32'h1, `UOY_RESP_OKAY);
        chk(irq, 1'b0);
        rd(`UOY_OFS_STAT, 32'h7E, `UOY_RESP_OKAY);
        rd(12'h0E0, 32'h0, `UOY_RESP_SLVERR);
        wr(12'h108, 32'h1, `UOY_RESP_SLVERR);
        complete_run();
    end
endmodule : testbench
bind uoy_ep_cfg uoy_properties #(.NUM_EP(NUM_EP)) i_props (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .pkt, .ep_iso, .ep_nack, .y_start_addr);
`default_nettype wire

// ==== testbench/uoy_host_model.sv ====
// Purpose: Host side of OUT transfers, seen as buffer manager completions.
// Assumes: Completion follows one cycle after the bench asks for a packet.
// Notes:   A NACKed packet is dropped; a real host would retry it later.
`timescale 1ns/1ps
`default_nettype none
module uoy_host_model
    import uoy_pkg::*;
#(parameter int NUM_EP = 7) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              go,
    input  wire logic [2:0]        go_ep,
    input  wire logic [9:0]        go_bytes,
    input  wire logic [NUM_EP-1:0] ep_nack,
    output var  uoy_pkt_t          pkt
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pkt <= '0;
        end else if (go && !ep_nack[go_ep]) begin
            pkt <= {1'b1, go_ep, go_bytes};
        end else begin
            // Idle fields toggle so a design that ignores done is caught.
            pkt <= {1'b0, ~pkt.ep, ~pkt.bytes};
        end
    end
endmodule : uoy_host_model
`default_nettype wire

// ==== testbench/uoy_properties.sv ====
// Purpose: Bus and endpoint checks for uoy_ep_cfg.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module uoy_properties
    import uoy_pkg::*;
#(parameter int NUM_EP = 7) (
    input wire logic                    aclk,
    input wire logic                    aresetn,
    input wire logic                    s_axi_awvalid,
    input wire logic                    s_axi_awready,
    input wire logic                    s_axi_wvalid,
    input wire logic                    s_axi_wready,
    input wire logic                    s_axi_bvalid,
    input wire logic                    s_axi_bready,
    input wire logic                    s_axi_arvalid,
    input wire logic                    s_axi_arready,
    input wire logic                    s_axi_rvalid,
    input wire logic                    s_axi_rready,
    input wire uoy_pkt_t                pkt,
    input wire logic [NUM_EP-1:0]       ep_iso,
    input wire logic [NUM_EP-1:0]       ep_nack,
    input wire logic [NUM_EP-1:0][10:0] y_start_addr
);
    logic low_set;
    always_comb begin
        low_set = 1'b0;
        for (int e = 0; e < NUM_EP; e++) low_set = low_set | (|y_start_addr[e][2:0]);
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_start_aligned: assert property (!low_set) else $error("start address unaligned");
    a_nack_on_pkt: assert property (pkt.done && pkt.ep < NUM_EP && !ep_iso[pkt.ep]
        |=> ep_nack[$past(pkt.ep)]) else $error("no nack after packet");
    a_iso_no_nack: assert property ((ep_nack & ep_iso) == '0) else $error("iso nack");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer timing");
    a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
    a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response stuck");
endmodule : uoy_properties
`default_nettype wire
